// File: testbench/adcpp_host.sv
/*
  Host bus model for the parallel data port: strobed reads and writes.
  Assumes the bench calls xfer from one process and reads cap/cap_oe.
*/
`timescale 1ns/1ps
module adcpp_host
(
  input  wire logic                          ref_clk,
  input  wire logic                          word_mode,
  output logic                               cs_n,
  output logic                               rd_n,
  output logic                               wr_n,
  output logic [adcpp_pkg::LOW_W-1:0]        low_in,
  output logic                               sh_in,
  output logic [adcpp_pkg::UPPER_W-1:0]      up_in,
  input  wire logic [adcpp_pkg::LOW_W-1:0]   dev_low,
  input  wire logic                          dev_low_oe,
  input  wire logic                          dev_b8,
  input  wire logic                          dev_b8_oe,
  input  wire logic [adcpp_pkg::UPPER_W-1:0] dev_up,
  input  wire logic                          dev_up_oe
);
  import adcpp_pkg::*;
  logic              drv = 1'b0;
  logic              sh_en = 1'b0;
  logic              sh_v = 1'b0;
  logic [WORD_W-1:0] h_d = 12'h000;
  logic [WORD_W-1:0] last = 12'h000;
  logic [WORD_W-1:0] cap;
  logic [2:0]        cap_oe;
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
  end
  // Undriven lines show the inverse of their last level, so a missing
  // drive never passes for a plausible value.
  assign low_in = drv ? h_d[7:0] : dev_low_oe ? dev_low : ~last[7:0];
  assign sh_in  = sh_en ? sh_v : dev_b8_oe ? dev_b8 : ~last[8];
  assign up_in  = drv ? h_d[11:9] : dev_up_oe ? dev_up : ~last[11:9];
  always_ff @(posedge ref_clk)
    last <= {up_in, sh_in, low_in};
  task automatic xfer(input logic is_wr, input logic cs, input logic sel,
                      input logic [WORD_W-1:0] d);
    @(negedge ref_clk);
    cs_n = !cs;
    rd_n = is_wr;
    wr_n = !is_wr;
    drv = is_wr;
    h_d = d;
    sh_en = is_wr | !word_mode;
    sh_v = word_mode ? d[8] : sel;
    @(negedge ref_clk);
    cap = {up_in, sh_in, low_in};
    cap_oe = {dev_up_oe, dev_b8_oe, dev_low_oe};
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    drv = 1'b0;
    sh_en = !word_mode;
  endtask
endmodule

// File: testbench/adcpp_port_tb_top.sv
/*
  Self-checking bench for the parallel host data port.
  Assumes the host model drives all bus pins from the falling edge.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module adcpp_port_tb_top;
  import adcpp_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic word_mode = 1'b1;
  logic ten_bit = 1'b0;
  logic cs_n, rd_n, wr_n, sh_in, b8_o, b8_oe, lo_oe, up_oe, reg_written;
  logic [LOW_W-1:0] lo_in, lo_o;
  logic [UPPER_W-1:0] up_in, up_o;
  logic [WORD_W-1:0] result = 12'h000;
  logic [WORD_W-1:0] view;
  logic [CHAN_W-1:0] chan = 3'h0;
  logic [REG_SEL_W-1:0] wsel = SEL_CONTROL;
  logic [REG_SEL_W-1:0] vsel = SEL_CONTROL;
  int fails = 0;
  int compares = 0;
  initial forever #2.5 ref_clk = ~ref_clk;
  adcpp_port adcpp_port_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .word_mode(word_mode),
    .ten_bit_variant(ten_bit), .low_data_lines_in(lo_in),
    .low_data_lines_out(lo_o), .low_data_lines_oe(lo_oe),
    .bit8_or_upper_half_select_in(sh_in), .bit8_out(b8_o),
    .bit8_oe(b8_oe), .upper_data_lines_in(up_in),
    .upper_data_lines_out(up_o), .upper_data_lines_oe(up_oe),
    .result(result), .result_chan(chan), .write_sel(wsel),
    .view_sel(vsel), .view_data_ff(view), .reg_written(reg_written));
  adcpp_host adcpp_host_inst (.ref_clk(ref_clk), .word_mode(word_mode),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .low_in(lo_in), .sh_in(sh_in),
    .up_in(up_in), .dev_low(lo_o), .dev_low_oe(lo_oe), .dev_b8(b8_o),
    .dev_b8_oe(b8_oe), .dev_up(up_o), .dev_up_oe(up_oe));
  task automatic setup(input logic wm, input logic tb,
                       input logic [WORD_W-1:0] r, input logic [2:0] ch);
    @(negedge ref_clk);
    word_mode = wm;
    ten_bit = tb;
    result = r;
    chan = ch;
  endtask
  task automatic rd(input logic cs, input logic sel);
    adcpp_host_inst.xfer(1'b0, cs, sel, 12'h000);
  endtask
  // A commit pulse must show within six cycles of the strobe end.
  task automatic wait_wr(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (6)
    begin
      @(negedge ref_clk);
      if (reg_written === 1'b1) seen = 1'b1;
    end
    `CHK("reg_written", exp, seen)
  endtask
  task automatic t_word_read;
    setup(1'b1, 1'b0, 12'hA5C, 3'h2);
    rd(1'b1, 1'b0);
    `CHK("word_rd", 12'hA5C, adcpp_host_inst.cap)
    `CHK("word_oe", 3'h7, adcpp_host_inst.cap_oe)
    repeat (2) @(negedge ref_clk);
    `CHK("rel_oe", 3'h0, {up_oe, b8_oe, lo_oe})
    rd(1'b0, 1'b0);
    `CHK("nocs_oe", 3'h0, adcpp_host_inst.cap_oe)
    $display("test word_read done");
  endtask
  task automatic t_byte_read(input logic tb, input logic [11:0] r,
                             input logic [11:0] w);
    setup(1'b0, tb, r, 3'h5);
    rd(1'b1, 1'b0);
    `CHK("lo_byte", w[7:0], adcpp_host_inst.cap[7:0])
    `CHK("byte_oe", 3'h1, adcpp_host_inst.cap_oe)
    rd(1'b1, 1'b1);
    `CHK("hi_byte", {1'b0, 3'h5, w[11:8]}, adcpp_host_inst.cap[7:0])
    setup(1'b1, tb, r, 3'h5);
    rd(1'b1, 1'b0);
    `CHK("word_rd", w, adcpp_host_inst.cap)
    $display("test byte_read done");
  endtask
  task automatic t_word_write;
    setup(1'b1, 1'b0, 12'h000, 3'h0);
    adcpp_host_inst.xfer(1'b1, 1'b1, 1'b0, 12'h9A7);
    wait_wr(1'b1);
    `CHK("ctl_reg", 12'h9A7, view)
    adcpp_host_inst.xfer(1'b1, 1'b0, 1'b0, 12'h111);
    wait_wr(1'b0);
    `CHK("ctl_keep", 12'h9A7, view)
    $display("test word_write done");
  endtask
  task automatic t_byte_write;
    setup(1'b0, 1'b0, 12'h000, 3'h0);
    wsel = SEL_SHADOW;
    vsel = SEL_SHADOW;
    adcpp_host_inst.xfer(1'b1, 1'b1, 1'b0, 12'h034);
    wait_wr(1'b0);
    adcpp_host_inst.xfer(1'b1, 1'b1, 1'b1, 12'h00B);
    wait_wr(1'b1);
    `CHK("shd_reg", 12'hB34, view)
    $display("test byte_write done");
  endtask
  task automatic summarize;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk);
    `CHK("rst_oe", 3'h0, {up_oe, b8_oe, lo_oe})
    @(negedge ref_clk);
    reset_n = 1'b1;
    t_word_read();
    t_byte_read(1'b0, 12'hC37, 12'hC37);
    t_byte_read(1'b1, 12'hAD7, 12'hB5C);
    t_word_write();
    t_byte_write();
    summarize();
  end
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    fails++;
    summarize();
  end
endmodule

// File: verilog/adcpp_pkg.sv
/*
  Package for the converter's parallel host data port: pin widths,
  result layout, reset values and the register write carrier.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package adcpp_pkg;

  localparam int unsigned WORD_W      = 12;
  localparam int unsigned LOW_W       = 8;
  localparam int unsigned UPPER_W     = 3;
  localparam int unsigned CHAN_W      = 3;
  localparam int unsigned NIB_W       = 4;
  localparam int unsigned REG_CNT     = 2;
  localparam int unsigned REG_SEL_W   = 1;

  // Field positions in the high byte of a byte-mode transfer and in the data word.
  localparam int unsigned HI_NIB_LSB  = 0;
  localparam int unsigned HI_CHAN_LSB = 4;
  localparam int unsigned BIT8_POS    = 8;
  localparam int unsigned UPPER_LSB   = 9;
  localparam int unsigned TEN_PAD_W   = 2;

  localparam logic [WORD_W-1:0] WORD_RST = 12'h000;
  localparam logic [LOW_W-1:0]  LOW_RST  = 8'h00;

  // Register index written by the host.
  localparam logic [REG_SEL_W-1:0] SEL_CONTROL = 1'h0;
  localparam logic [REG_SEL_W-1:0] SEL_SHADOW  = 1'h1;

  typedef struct packed {
    logic                 en;
    logic [REG_SEL_W-1:0] sel;
    logic [WORD_W-1:0]    data;
  } adcpp_wreq_t;

endpackage

// File: verilog/adcpp_port.sv
/*
  Parallel host data port: drives conversion results on reads and takes
  control and shadow register values on writes, in word or byte mode.
  Assumes all pin inputs are synchronous to ref_clk and that the core
  holds the result and channel stable while a read is in progress.
*/
`timescale 1ns/1ps
// Functional notes
// RULE1 - Low eight lines three-state, gated by strobes
// RULE2 - Ten-bit reads drive two LSB lines zero
// RULE3 - Word mode: shared pin is data bit eight
// RULE4 - Byte mode: shared pin selects upper half
// RULE5 - Byte mode: low byte or top nibble
// RULE6 - High-byte read carries channel on lines 4-6
// RULE7 - Host writes zeros in high-byte bits 7-4
// RULE8 - Ten-bit low-byte read: two zero LSBs
// RULE9 - Read drives result while select low
// RULE10 - Write takes effect only with select low
// RULE11 - Word mode upper lines read and write
// RULE12 - Lines released when not selected for read
module adcpp_port
(
  input  wire logic                              ref_clk,
  input  wire logic                              reset_n,
  input  wire logic                              cs_n,
  input  wire logic                              rd_n,
  input  wire logic                              wr_n,
  input  wire logic                              word_mode,
  input  wire logic                              ten_bit_variant,
  input  wire logic [adcpp_pkg::LOW_W-1:0]       low_data_lines_in,
  output logic      [adcpp_pkg::LOW_W-1:0]       low_data_lines_out,
  output logic                                   low_data_lines_oe,
  input  wire logic                              bit8_or_upper_half_select_in,
  output logic                                   bit8_out,
  output logic                                   bit8_oe,
  input  wire logic [adcpp_pkg::UPPER_W-1:0]     upper_data_lines_in,
  output logic      [adcpp_pkg::UPPER_W-1:0]     upper_data_lines_out,
  output logic                                   upper_data_lines_oe,
  input  wire logic [adcpp_pkg::WORD_W-1:0]      result,
  input  wire logic [adcpp_pkg::CHAN_W-1:0]      result_chan,
  input  wire logic [adcpp_pkg::REG_SEL_W-1:0]   write_sel,
  input  wire logic [adcpp_pkg::REG_SEL_W-1:0]   view_sel,
  output logic      [adcpp_pkg::WORD_W-1:0]      view_data_ff,
  output logic                                   reg_written
);
  import adcpp_pkg::*;

  // ***************************************************************
  // Strobe decode and read data selection
  // ***************************************************************
  logic              rd_act;
  logic              wr_act;
  logic              upper_sel;
  logic [WORD_W-1:0] res_word;
  logic [LOW_W-1:0]  hi_byte;
  logic [LOW_W-1:0]  nxt_low;
  logic [WORD_W-1:0] pin_word;
  logic              wr_end;

  assign rd_act    = !cs_n && !rd_n; // RULE9
  assign wr_act    = !cs_n && !wr_n; // RULE10
  assign upper_sel = !word_mode && bit8_or_upper_half_select_in; // RULE4
  // The ten-bit core value sits in the low bits of result.
  assign res_word  = ten_bit_variant ?
                     {result[WORD_W-TEN_PAD_W-1:0], {TEN_PAD_W{1'b0}}} :
                     result; // RULE2 RULE8
  assign hi_byte   = {1'b0, result_chan,
                      res_word[WORD_W-1:LOW_W]}; // RULE6
  assign nxt_low   = upper_sel ? hi_byte : res_word[LOW_W-1:0]; // RULE5
  assign pin_word  = {upper_data_lines_in, bit8_or_upper_half_select_in,
                      low_data_lines_in}; // RULE11 RULE3

  // ***************************************************************
  // Output drivers
  // ***************************************************************
  logic              rd_oe_ff;
  logic              word_oe_ff;
  logic [LOW_W-1:0]  low_ff;
  logic              bit8_ff;
  logic [UPPER_W-1:0] upper_ff;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_oe_ff   <= 1'b0;
      word_oe_ff <= 1'b0;
      low_ff     <= LOW_RST;
      bit8_ff    <= 1'b0;
      upper_ff   <= '0;
    end
    else
    begin
      rd_oe_ff   <= rd_act; // RULE1 RULE12
      word_oe_ff <= rd_act && word_mode; // RULE3 RULE11
      low_ff     <= word_mode ? res_word[LOW_W-1:0] : nxt_low;
      bit8_ff    <= word_mode && res_word[BIT8_POS];
      upper_ff   <= word_mode ? res_word[WORD_W-1:UPPER_LSB] : '0;
    end
  end

  assign low_data_lines_out   = low_ff;
  assign low_data_lines_oe    = rd_oe_ff;
  assign bit8_out             = bit8_ff;
  assign bit8_oe              = word_oe_ff;
  assign upper_data_lines_out = upper_ff;
  assign upper_data_lines_oe  = word_oe_ff;

  // ***************************************************************
  // Write capture
  // ***************************************************************
  // Data is latched while the strobe is active and committed when it
  // ends, so the value of the final active cycle is the one kept.
  logic              wr_act_ff;
  logic              wr_upper_ff;
  logic              wr_word_ff;
  logic [WORD_W-1:0] wr_pin_ff;
  logic [LOW_W-1:0]  pend_low_ff;
  logic              written_ff;
  adcpp_wreq_t       wreq;

  assign wr_end = wr_act_ff && !wr_act;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_act_ff   <= 1'b0;
      wr_upper_ff <= 1'b0;
      wr_word_ff  <= 1'b0;
      wr_pin_ff   <= WORD_RST;
      pend_low_ff <= LOW_RST;
      written_ff  <= 1'b0;
    end
    else
    begin
      wr_act_ff  <= wr_act;
      written_ff <= wreq.en;
      if (wr_act)
      begin
        wr_pin_ff   <= pin_word;
        wr_upper_ff <= upper_sel;
        wr_word_ff  <= word_mode;
      end
      if (wr_end && !wr_word_ff && !wr_upper_ff)
        pend_low_ff <= wr_pin_ff[LOW_W-1:0]; // RULE5
    end
  end

  // A byte-mode register only changes once its high half arrives; the
  // host's zero bits 7-4 of that byte are not looked at.
  assign wreq.en   = wr_end && (wr_word_ff || wr_upper_ff); // RULE10
  assign wreq.sel  = write_sel;
  assign wreq.data = wr_word_ff ? wr_pin_ff :
                     {wr_pin_ff[HI_NIB_LSB+NIB_W-1:HI_NIB_LSB],
                      pend_low_ff}; // RULE5 RULE7

  assign reg_written = written_ff;

  adcpp_regs adcpp_regs_inst
  (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .wreq       (wreq),
    .rd_sel     (view_sel),
    .rd_data_ff (view_data_ff)
  );

  // ***************************************************************
  // Assertions
  // ***************************************************************
  property p_oe_follows_read;
    @(posedge ref_clk) disable iff (!reset_n)
      rd_act |=> low_data_lines_oe;
  endproperty
  a_oe_follows_read: assert property (p_oe_follows_read) // RULE9
    else $error("low lines not driven after read strobe");

  property p_release;
    @(posedge ref_clk) disable iff (!reset_n)
      (cs_n || rd_n) |=> !low_data_lines_oe && !upper_data_lines_oe;
  endproperty
  a_release: assert property (p_release) // RULE12
    else $error("data lines driven without read");

  property p_ten_lsb;
    @(posedge ref_clk) disable iff (!reset_n)
      (rd_act && ten_bit_variant && !upper_sel)
        |=> low_data_lines_out[1:0] == 2'h0;
  endproperty
  a_ten_lsb: assert property (p_ten_lsb) // RULE2
    else $error("ten-bit read low bits not zero");

  property p_ten_lsb_pos;
    @(posedge ref_clk) disable iff (!reset_n)
      (rd_act && ten_bit_variant && !upper_sel)
        |=> low_data_lines_out[2] == $past(result[0]);
  endproperty
  a_ten_lsb_pos: assert property (p_ten_lsb_pos) // RULE8
    else $error("ten-bit result lsb not on line two");

  property p_byte_no_upper;
    @(posedge ref_clk) disable iff (!reset_n)
      !word_mode |=> !bit8_oe && !upper_data_lines_oe;
  endproperty
  a_byte_no_upper: assert property (p_byte_no_upper) // RULE4
    else $error("shared pin driven in byte mode");

  property p_word_bit8;
    @(posedge ref_clk) disable iff (!reset_n)
      (rd_act && word_mode) |=>
        bit8_oe &&
        bit8_out == $past(ten_bit_variant ? result[6] : result[8]);
  endproperty
  a_word_bit8: assert property (p_word_bit8) // RULE3
    else $error("bit eight wrong in word mode");

  property p_high_chan;
    @(posedge ref_clk) disable iff (!reset_n)
      (rd_act && upper_sel) |=>
        low_data_lines_out[7] == 1'b0 &&
        low_data_lines_out[6:4] == $past(result_chan) &&
        low_data_lines_out[3:0] ==
          $past(ten_bit_variant ? result[9:6] : result[11:8]);
  endproperty
  a_high_chan: assert property (p_high_chan) // RULE6
    else $error("high byte read content wrong");

  property p_word_upper;
    @(posedge ref_clk) disable iff (!reset_n)
      (rd_act && word_mode) |=>
        upper_data_lines_out ==
          $past(ten_bit_variant ? result[9:7] : result[11:9]);
  endproperty
  a_word_upper: assert property (p_word_upper) // RULE11
    else $error("upper lines wrong in word mode");

  property p_write_needs_cs;
    @(posedge ref_clk) disable iff (!reset_n)
      wreq.en |-> $past(!cs_n && !wr_n);
  endproperty
  a_write_needs_cs: assert property (p_write_needs_cs) // RULE10
    else $error("register write without select and strobe");

  property p_low_byte_no_commit;
    @(posedge ref_clk) disable iff (!reset_n)
      (wr_end && !wr_word_ff && !wr_upper_ff) |=> !reg_written;
  endproperty
  a_low_byte_no_commit: assert property (p_low_byte_no_commit) // RULE5
    else $error("low byte write committed a register");

  property p_oe_common;
    @(posedge ref_clk) disable iff (!reset_n)
      upper_data_lines_oe |-> low_data_lines_oe;
  endproperty
  a_oe_common: assert property (p_oe_common) // RULE1
    else $error("upper lines driven without low lines");

  c_word_read:  cover property (@(posedge ref_clk) rd_act && word_mode);
  c_high_read:  cover property (@(posedge ref_clk) rd_act && upper_sel);
  c_byte_write: cover property (@(posedge ref_clk)
                                wreq.en && !wr_word_ff);
  c_word_write: cover property (@(posedge ref_clk) wreq.en && wr_word_ff);

endmodule

// File: verilog/adcpp_regs.sv
/*
  Control and shadow register store of the host port.
  Assumes one write request per cycle at most; read data is registered.
*/
`timescale 1ns/1ps
module adcpp_regs
(
  input  wire logic                              ref_clk,
  input  wire logic                              reset_n,
  input  wire adcpp_pkg::adcpp_wreq_t            wreq,
  input  wire logic [adcpp_pkg::REG_SEL_W-1:0]   rd_sel,
  output logic      [adcpp_pkg::WORD_W-1:0]      rd_data_ff
);
  import adcpp_pkg::*;

  logic [WORD_W-1:0] mem_ff [REG_CNT];

  genvar gi;
  generate
    for (gi = 0; gi < REG_CNT; gi++)
    begin : g_word
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
          mem_ff[gi] <= WORD_RST;
        else if (wreq.en && (wreq.sel == REG_SEL_W'(gi)))
          mem_ff[gi] <= wreq.data;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rd_data_ff <= WORD_RST;
    else
      rd_data_ff <= mem_ff[rd_sel];
  end

endmodule
